// ==== logic/pdgl_defines.svh ====
// constants for the predistortion and gain loop control block
`ifndef PDGL_DEFINES_SVH
`define PDGL_DEFINES_SVH

`define MCLK_PERIOD_NS      10
`define NS_PER_US           1000
`define CYCLES_PER_US       (`NS_PER_US / `MCLK_PERIOD_NS)
`define US_TICK_W           7

`define CAPTURE_MAX_SAMPLES 13'h1000
`define COUNT_W             13
`define DELAY_US_W          16
`define PATH_DELAY_W        8

`define TABLE_DEPTH         16
`define TABLE_ADDR_W        4
`define TABLE_WORD_W        32
`define TABLE_UNITY         32'h4000_0000
`define TABLE_ZERO          32'h0000_0000

`define COEFF_W             17
`define COEFF_ONE           17'h1_0000
`define COEFF_FRAC          16
`define GAIN_COEFF_RESET    17'h0_C000

`define GAIN_W              32
`define GAIN_DEADBAND       32'h0000_000A
`define ATTEN_W             10
`define ATTEN_RESET         10'h000
`define ATTEN_MAX           10'h3FF

`define SAMPLE_RATE_W       32
`define SAMPLE_RATE_HZ      32'h0000_0000

`endif

// ==== logic/pdgl_pkg.sv ====
// types shared by the predistortion and gain loop control block
`default_nettype none
package pdgl_pkg;

	typedef enum logic [2:0] {
		CAP_IDLE    = 3'b000,
		CAP_DELAY   = 3'b001,
		CAP_ALIGN   = 3'b011,
		CAP_COLLECT = 3'b010,
		CAP_JUDGE   = 3'b110
	} capture_state_t;

endpackage : pdgl_pkg
`default_nettype wire

// ==== logic/predistortion_gain_loop_control.sv ====
// capture qualification, table swap, smoothing and gain loop control
//
// Operation
// R1 - capture invalid when samples below power threshold exceed low-power limit
// R2 - low-power limit of 4096 disables the low-power check
// R3 - capture valid only when samples above peak threshold exceed peak limit
// R4 - peak limit of zero disables the peak check
// R5 - new solution is written into the spare table, later exchanged
// R6 - immediate swap exchanges tables as soon as spare is ready
// R7 - deferred swap waits for next frame end after spare is ready
// R8 - table reset clears all terms except the unity term
// R9 - table output smoothed by single-pole filter; zero coefficient disables
// R10 - loop open: attenuators frozen, gain only measured
// R11 - loop closed: attenuators steered toward the gain target
// R12 - gain target is signed, hundredth-decibel units
// R13 - gain measurement smoothed, coefficient defaults to 0.75, zero bypasses
// R14 - loop open: unfiltered gain reported read-only
// R15 - loop open: filtered gain reported read-only
// R16 - capture starts configured microseconds after frame start, default zero
// R17 - one capture setup serves both predistortion and gain control
// R18 - loopback path delay skipped before observation samples are counted
// R19 - sample rate is an output only, nothing can change it
// R20 - a capture holds at most 4096 samples
// R21 - only qualified captures update table or attenuators
// R22 - filter: y plus (one minus coeff) times (x minus y)
`include "pdgl_defines.svh"
`default_nettype none

module predistortion_gain_loop_control
	import pdgl_pkg::*;
(
	input  wire logic                        i_mclk,                  // 100 MHz clock
	input  wire logic                        i_rst,                   // sync reset, active high
	input  wire logic [31:0]                 i_low_power_threshold,   // U1.31 power floor
	input  wire logic [31:0]                 i_peak_level_threshold,  // U1.31 peak level
	input  wire logic [`COUNT_W-1:0]         i_low_power_count_limit, // low-power sample limit
	input  wire logic [`COUNT_W-1:0]         i_peak_count_limit,      // peak sample limit
	input  wire logic [`COUNT_W-1:0]         i_sample_count,          // samples per capture
	input  wire logic [`DELAY_US_W-1:0]      i_capture_start_delay,   // delay in microseconds
	input  wire logic [`PATH_DELAY_W-1:0]    i_loopback_path_delay,   // loopback delay, samples
	input  wire logic                        i_immediate_table_swap,  // swap as soon as ready
	input  wire logic                        i_table_reset,           // clear both tables
	input  wire logic [`COEFF_W-1:0]         i_swap_smoothing_coeff,  // U1.16 table filter
	input  wire logic                        i_gain_loop_open,        // 1 = loop open
	input  wire logic signed [`GAIN_W-1:0]   i_gain_target,           // 0.01 dB units
	input  wire logic [`COEFF_W-1:0]         i_gain_smoothing_coeff,  // U1.16 gain filter
	input  wire logic                        i_frame_start,           // tx frame start pulse
	input  wire logic                        i_frame_end,             // tx frame end pulse
	input  wire logic                        i_obs_valid,             // observation sample valid
	input  wire logic [31:0]                 i_obs_power,             // observation sample power
	input  wire logic                        i_solution_valid,        // solution word valid
	input  wire logic [`TABLE_WORD_W-1:0]    i_solution_word,         // solution word
	input  wire logic                        i_solution_last,         // last word of solution
	output logic                             o_solution_ready,        // buffer can take a word
	input  wire logic                        i_gain_valid,            // gain measurement pulse
	input  wire logic signed [`GAIN_W-1:0]   i_gain_meas,             // instantaneous gain
	input  wire logic                        i_lut_rd,                // table read request
	input  wire logic [`TABLE_ADDR_W-1:0]    i_lut_addr,              // table read address
	output logic signed [`TABLE_WORD_W-1:0]  o_lut_data,              // smoothed table word, reg
	output logic                             o_lut_data_valid,        // read data pulse, reg
	output logic                             o_table_bank,            // active table, reg
	output logic                             o_capture_busy,          // capture running
	output logic                             o_capture_done,          // judgement pulse, reg
	output logic                             o_capture_valid,         // last capture passed, reg
	output logic signed [`GAIN_W-1:0]        o_raw_gain_reading,      // unfiltered gain, reg
	output logic signed [`GAIN_W-1:0]        o_smoothed_gain_reading, // filtered gain, reg
	output logic [`ATTEN_W-1:0]              o_tx_atten,              // attenuator word, reg
	output logic                             o_atten_update,          // attenuator changed, reg
	output logic [`SAMPLE_RATE_W-1:0]        o_predistortion_sample_rate // fixed rate
);

	function automatic logic signed [31:0] pole_filter(
		input logic signed [31:0] prev,
		input logic signed [31:0] sample,
		input logic [`COEFF_W-1:0] coeff
	);
		logic signed [32:0] diff;
		logic signed [17:0] gain;
		logic signed [50:0] prod;
		logic signed [33:0] sum;
		diff = 33'(sample) - 33'(prev);
		gain = 18'(signed'({1'b0, `COEFF_ONE})) - 18'(signed'({1'b0, coeff}));
		prod = 51'(diff) * 51'(gain);
		sum = 34'(prev) + 34'(prod >>> `COEFF_FRAC);
		return sum[31:0]; // R22
	endfunction : pole_filter

	// capture sequencer
	capture_state_t             state,       next_state;
	logic [`US_TICK_W-1:0]      us_tick,     next_us_tick;
	logic [`DELAY_US_W-1:0]     delay_cnt,   next_delay_cnt;
	logic [`PATH_DELAY_W-1:0]   align_cnt,   next_align_cnt;
	logic [`COUNT_W-1:0]        sample_cnt,  next_sample_cnt;
	logic [`COUNT_W-1:0]        low_cnt,     next_low_cnt;
	logic [`COUNT_W-1:0]        peak_cnt,    next_peak_cnt;
	logic [`COUNT_W-1:0]        target_len;
	logic                       cap_done,    next_cap_done;
	logic                       cap_valid,   next_cap_valid;
	logic                       low_bad;
	logic                       peak_ok;

	// a zero or oversize request becomes a full-length capture
	assign target_len = (i_sample_count == '0 || i_sample_count > `CAPTURE_MAX_SAMPLES)
		? `CAPTURE_MAX_SAMPLES : i_sample_count; // R20
	assign low_bad = (i_low_power_count_limit != `CAPTURE_MAX_SAMPLES)
		&& (low_cnt > i_low_power_count_limit); // R1 R2
	assign peak_ok = (i_peak_count_limit == '0)
		|| (peak_cnt > i_peak_count_limit); // R3 R4

	always_comb begin
		next_state      = state;
		next_us_tick    = us_tick;
		next_delay_cnt  = delay_cnt;
		next_align_cnt  = align_cnt;
		next_sample_cnt = sample_cnt;
		next_low_cnt    = low_cnt;
		next_peak_cnt   = peak_cnt;
		next_cap_done   = 1'b0;
		next_cap_valid  = cap_valid;
		case (state)
			CAP_IDLE: begin
				if (i_frame_start) begin // R17
					next_us_tick    = '0;
					next_delay_cnt  = '0;
					next_align_cnt  = '0;
					next_sample_cnt = '0;
					next_low_cnt    = '0;
					next_peak_cnt   = '0;
					next_state      = (i_capture_start_delay == '0) ? CAP_ALIGN : CAP_DELAY;
				end
			end
			CAP_DELAY: begin
				if (us_tick == `US_TICK_W'(`CYCLES_PER_US - 1)) begin
					next_us_tick   = '0;
					next_delay_cnt = delay_cnt + 1'b1;
					if (delay_cnt + 1'b1 == i_capture_start_delay) begin // R16
						next_state = CAP_ALIGN;
					end
				end else begin
					next_us_tick = us_tick + 1'b1;
				end
			end
			CAP_ALIGN: begin
				// observation samples still in flight on the loopback path are skipped
				// leave on the last skipped sample so the next one is counted, not lost
				if (align_cnt == i_loopback_path_delay) begin // R18
					next_state = CAP_COLLECT;
				end else if (i_obs_valid) begin
					next_align_cnt = align_cnt + 1'b1;
					if (align_cnt + 1'b1 == i_loopback_path_delay) begin // R18
						next_state = CAP_COLLECT;
					end
				end
			end
			CAP_COLLECT: begin
				if (i_obs_valid) begin
					next_sample_cnt = sample_cnt + 1'b1;
					if (i_obs_power < i_low_power_threshold) begin
						next_low_cnt = low_cnt + 1'b1;
					end
					if (i_obs_power > i_peak_level_threshold) begin
						next_peak_cnt = peak_cnt + 1'b1;
					end
					if (sample_cnt + 1'b1 == target_len) begin
						next_state = CAP_JUDGE;
					end
				end
			end
			CAP_JUDGE: begin
				next_cap_valid = !low_bad && peak_ok; // R21
				next_cap_done  = 1'b1;
				next_state     = CAP_IDLE;
			end
			default: begin
				next_state = CAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state      <= CAP_IDLE;
			us_tick    <= '0;
			delay_cnt  <= '0;
			align_cnt  <= '0;
			sample_cnt <= '0;
			low_cnt    <= '0;
			peak_cnt   <= '0;
			cap_done   <= 1'b0;
			cap_valid  <= 1'b0;
		end else begin
			state      <= next_state;
			us_tick    <= next_us_tick;
			delay_cnt  <= next_delay_cnt;
			align_cnt  <= next_align_cnt;
			sample_cnt <= next_sample_cnt;
			low_cnt    <= next_low_cnt;
			peak_cnt   <= next_peak_cnt;
			cap_done   <= next_cap_done;
			cap_valid  <= next_cap_valid;
		end
	end

	// two-entry buffer on the solution words
	logic [`TABLE_WORD_W:0] buf_data [0:1];
	logic [1:0]             buf_cnt,   next_buf_cnt;
	logic                   buf_rd,    next_buf_rd;
	logic                   buf_wr,    next_buf_wr;
	logic                   buf_in_go;
	logic                   buf_out_go;
	logic                   buf_out_valid;
	logic                   drain_ready;

	// words wait while the spare table holds an unswapped solution or a clear runs
	logic                   spare_ready, next_spare_ready;
	logic                   active_bank, next_active_bank;
	logic [`TABLE_ADDR_W-1:0] wr_addr,   next_wr_addr;

	assign o_solution_ready = (buf_cnt != 2'd2);
	assign buf_out_valid    = (buf_cnt != 2'd0);
	assign drain_ready      = !spare_ready && !i_table_reset;
	assign buf_in_go        = i_solution_valid && o_solution_ready;
	assign buf_out_go       = buf_out_valid && drain_ready;

	always_comb begin
		next_buf_cnt = buf_cnt;
		next_buf_rd  = buf_rd;
		next_buf_wr  = buf_wr;
		if (buf_in_go) begin
			next_buf_wr = ~buf_wr;
		end
		if (buf_out_go) begin
			next_buf_rd = ~buf_rd;
		end
		if (buf_in_go && !buf_out_go) begin
			next_buf_cnt = buf_cnt + 2'd1;
		end else if (!buf_in_go && buf_out_go) begin
			next_buf_cnt = buf_cnt - 2'd1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			buf_cnt <= 2'd0;
			buf_rd  <= 1'b0;
			buf_wr  <= 1'b0;
		end else begin
			buf_cnt <= next_buf_cnt;
			buf_rd  <= next_buf_rd;
			buf_wr  <= next_buf_wr;
		end
		if (buf_in_go) begin
			buf_data[buf_wr] <= {i_solution_last, i_solution_word};
		end
	end

	// table banks and swap control
	logic [`TABLE_WORD_W-1:0] table_mem [0:2*`TABLE_DEPTH-1];
	logic                     swap_now;
	logic                     swap_armed, next_swap_armed;
	logic                     word_last;

	assign word_last = buf_data[buf_rd][`TABLE_WORD_W];
	// a rejected capture keeps the solution parked in the spare bank
	assign swap_now  = spare_ready && cap_valid && (i_immediate_table_swap
		|| (swap_armed && i_frame_end)); // R6 R7 R21

	always_comb begin
		next_spare_ready = spare_ready;
		next_active_bank = active_bank;
		next_wr_addr     = wr_addr;
		next_swap_armed  = swap_armed;
		if (buf_out_go) begin
			next_wr_addr = word_last ? '0 : wr_addr + 1'b1;
			if (word_last) begin
				next_spare_ready = 1'b1; // R5
				next_swap_armed  = 1'b1;
			end
		end
		if (swap_now) begin
			next_active_bank = ~active_bank; // R5
			next_spare_ready = 1'b0;
			next_swap_armed  = 1'b0;
		end
		if (i_table_reset) begin
			next_spare_ready = 1'b0;
			next_swap_armed  = 1'b0;
			next_wr_addr     = '0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			spare_ready <= 1'b0;
			active_bank <= 1'b0;
			wr_addr     <= '0;
			swap_armed  <= 1'b0;
		end else begin
			spare_ready <= next_spare_ready;
			active_bank <= next_active_bank;
			wr_addr     <= next_wr_addr;
			swap_armed  <= next_swap_armed;
		end
		if (i_table_reset) begin
			for (int i = 0; i < 2*`TABLE_DEPTH; i++) begin
				// the first term of each bank stays at unity so the path passes through
				table_mem[i] <= ((i % `TABLE_DEPTH) == 0) ? `TABLE_UNITY : `TABLE_ZERO; // R8
			end
		end else if (buf_out_go) begin
			table_mem[{~active_bank, wr_addr}] <= buf_data[buf_rd][`TABLE_WORD_W-1:0]; // R5
		end
	end

	// smoothed table readout; the filter damps the step at a swap
	logic signed [`TABLE_WORD_W-1:0] lut_data,  next_lut_data;
	logic                            lut_vld,   next_lut_vld;

	always_comb begin
		next_lut_data = lut_data;
		next_lut_vld  = i_lut_rd;
		if (i_lut_rd) begin
			next_lut_data = pole_filter(lut_data, table_mem[{active_bank, i_lut_addr}],
				i_swap_smoothing_coeff); // R9
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			lut_data <= '0;
			lut_vld  <= 1'b0;
		end else begin
			lut_data <= next_lut_data;
			lut_vld  <= next_lut_vld;
		end
	end

	// gain measurement and attenuator loop
	logic signed [`GAIN_W-1:0] raw_gain,   next_raw_gain;
	logic signed [`GAIN_W-1:0] filt_gain,  next_filt_gain;
	logic signed [`GAIN_W-1:0] rep_raw,    next_rep_raw;
	logic signed [`GAIN_W-1:0] rep_filt,   next_rep_filt;
	logic [`ATTEN_W-1:0]       atten,      next_atten;
	logic                      atten_upd,  next_atten_upd;
	logic signed [`GAIN_W:0]   gain_err;
	logic                      gain_take;

	assign gain_take = i_gain_valid && cap_valid; // R21

	always_comb begin
		next_raw_gain  = raw_gain;
		next_filt_gain = filt_gain;
		next_rep_raw   = rep_raw;
		next_rep_filt  = rep_filt;
		next_atten     = atten;
		next_atten_upd = 1'b0;
		if (gain_take) begin
			next_raw_gain  = i_gain_meas;
			next_filt_gain = pole_filter(filt_gain, i_gain_meas, i_gain_smoothing_coeff); // R13
		end
		gain_err = 33'(i_gain_target) - 33'(next_filt_gain); // R12
		if (gain_take && i_gain_loop_open) begin
			next_rep_raw  = next_raw_gain; // R14
			next_rep_filt = next_filt_gain; // R15
		end
		if (gain_take && !i_gain_loop_open) begin // R10 R11
			// one step per measurement keeps the loop slow and free of overshoot
			if (gain_err > 33'(signed'(`GAIN_DEADBAND)) && atten != '0) begin
				next_atten     = atten - 1'b1;
				next_atten_upd = 1'b1;
			end else if (gain_err < -33'(signed'(`GAIN_DEADBAND)) && atten != `ATTEN_MAX) begin
				next_atten     = atten + 1'b1;
				next_atten_upd = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			raw_gain  <= '0;
			filt_gain <= '0;
			rep_raw   <= '0;
			rep_filt  <= '0;
			atten     <= `ATTEN_RESET;
			atten_upd <= 1'b0;
		end else begin
			raw_gain  <= next_raw_gain;
			filt_gain <= next_filt_gain;
			rep_raw   <= next_rep_raw;
			rep_filt  <= next_rep_filt;
			atten     <= next_atten;
			atten_upd <= next_atten_upd;
		end
	end

	assign o_lut_data                  = lut_data;
	assign o_lut_data_valid            = lut_vld;
	assign o_table_bank                = active_bank;
	assign o_capture_busy              = (state != CAP_IDLE);
	assign o_capture_done              = cap_done;
	assign o_capture_valid             = cap_valid;
	assign o_raw_gain_reading          = rep_raw;
	assign o_smoothed_gain_reading     = rep_filt;
	assign o_tx_atten                  = atten;
	assign o_atten_update              = atten_upd;
	assign o_predistortion_sample_rate = `SAMPLE_RATE_HZ; // R19

endmodule : predistortion_gain_loop_control
`default_nettype wire

// ==== bench/pdgl_assertions.sv ====
// port assertions for the predistortion and gain loop control block
`include "pdgl_defines.svh"
`default_nettype none
module pdgl_assertions (
	input wire logic                i_mclk,
	input wire logic                i_rst,
	input wire logic                i_frame_start,
	input wire logic                i_lut_rd,
	input wire logic                i_gain_loop_open,
	input wire logic                i_gain_valid,
	input wire logic signed [31:0]  i_gain_meas,
	input wire logic [16:0]         i_gain_smoothing_coeff,
	input wire logic                o_lut_data_valid,
	input wire logic                o_table_bank,
	input wire logic                o_capture_busy,
	input wire logic                o_capture_done,
	input wire logic                o_capture_valid,
	input wire logic signed [31:0]  o_raw_gain_reading,
	input wire logic signed [31:0]  o_smoothed_gain_reading,
	input wire logic [9:0]          o_tx_atten,
	input wire logic                o_atten_update,
	input wire logic [31:0]         o_predistortion_sample_rate
);
	timeunit 1ns;
	timeprecision 1ps;
	// a measurement only counts once a qualified capture stands
	logic take_open;
	logic take_closed;
	assign take_open = i_gain_valid && o_capture_valid && i_gain_loop_open;
	assign take_closed = i_gain_valid && o_capture_valid && !i_gain_loop_open;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	a_start_busy: assert property (i_frame_start && !o_capture_busy |=> o_capture_busy)
		else $error("capture did not start");
	a_done_ends_busy: assert property (o_capture_done |-> !o_capture_busy && $past(o_capture_busy))
		else $error("done without a running capture");
	a_lut_answer: assert property (i_lut_rd |=> o_lut_data_valid)
		else $error("table read not answered");
	a_swap_gated: assert property (!o_capture_valid |=> $stable(o_table_bank))
		else $error("table swapped after a rejected capture");
	a_atten_frozen: assert property (i_gain_loop_open |=> $stable(o_tx_atten))
		else $error("attenuator moved with loop open");
	a_atten_step: assert property (o_atten_update |-> o_tx_atten - $past(o_tx_atten) == 10'h001
		|| $past(o_tx_atten) - o_tx_atten == 10'h001)
		else $error("attenuator step not one");
	a_update_cause: assert property (o_atten_update |-> $past(take_closed))
		else $error("attenuator update without measurement");
	a_raw_follows: assert property (take_open |=> o_raw_gain_reading == $past(i_gain_meas))
		else $error("raw gain not reported");
	a_smooth_bypass: assert property (take_open && i_gain_smoothing_coeff == 17'h0_0000
		|=> o_smoothed_gain_reading == $past(i_gain_meas))
		else $error("zero coefficient still filters");
	a_readings_hold: assert property (!i_gain_loop_open |=> $stable(o_raw_gain_reading)
		&& $stable(o_smoothed_gain_reading))
		else $error("readings changed with loop closed");
	a_rate_fixed: assert property (o_predistortion_sample_rate == `SAMPLE_RATE_HZ)
		else $error("sample rate changed");
	c_good_capture: cover property (o_capture_done && o_capture_valid);
	c_bank_swap: cover property ($changed(o_table_bank));
	c_atten_step: cover property (o_atten_update);
endmodule : pdgl_assertions
`default_nettype wire

// ==== bench/pa_loopback_model.sv ====
// loopback stand-in: streams observation sample powers
`default_nettype none
module pa_loopback_model (
	input  wire logic        i_mclk, // clock
	input  wire logic        i_go,   // start a burst
	input  wire logic        i_slow, // one sample every other cycle
	input  wire logic [12:0] i_skip, // samples lost in the path
	input  wire logic [12:0] i_n,    // counted samples
	input  wire logic [12:0] i_nlow, // low samples first
	input  wire logic [12:0] i_npk,  // then peak samples
	output logic             o_valid, // sample valid
	output logic [31:0]      o_power  // sample power
);
	timeunit 1ns;
	timeprecision 1ps;
	int k = -1;
	initial begin
		o_valid = 1'b0;
		o_power = 32'h0000_0000;
	end
	always @(posedge i_mclk) begin
		if (i_go)
			k = 0;
		// idle power toggles so stale values are never mistaken for samples
		if (k < 0 || (i_slow && o_valid)) begin
			o_valid <= 1'b0;
			o_power <= ~o_power;
		end else begin
			o_valid <= 1'b1;
			o_power <= (k < i_skip + i_nlow) ? 32'h0800_0000 :
				(k < i_skip + i_nlow + i_npk) ? 32'h7000_0000 : 32'h3000_0000;
			k = (k + 1 == i_skip + i_n) ? -1 : k + 1;
		end
	end
endmodule : pa_loopback_model
`default_nettype wire

// ==== bench/tb_predistortion_gain_loop_control.sv ====
// testbench for the predistortion and gain loop control block
`include "pdgl_defines.svh"
`default_nettype none
module tb_predistortion_gain_loop_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst = 1'b1, imm = 1'b1, trst = 1'b0, lopen = 1'b1, fs = 1'b0, fe = 1'b0;
	logic go = 1'b0, slow = 1'b0, sv = 1'b0, sl = 1'b0, gv = 1'b0, rd = 1'b0;
	logic [12:0] llim = 13'h1000, plim = 13'h0000, skip = 13'h0003, nlow = 13'h0000, npk = 13'h0000;
	logic [15:0] dly = 16'h0000;
	logic [16:0] gc = 17'h0_0000, sc = 17'h0_0000;
	logic signed [31:0] target = 32'sh0000_0000, meas = 32'sh0000_0000;
	logic [31:0] word = 32'h0000_0000;
	logic [3:0] addr = 4'h0;
	wire logic ov, rdy, rdv, bank, busy, done, ok, upd;
	wire logic [31:0] op, q, raw, smo, rate;
	wire logic [9:0] att;
	int fail_count = 0, num_checks = 0, cycles = 0;
	always #5 mclk = ~mclk;
	pa_loopback_model partner (.i_mclk(mclk), .i_go(go), .i_slow(slow), .i_skip(skip),
		.i_n(13'h0010), .i_nlow(nlow), .i_npk(npk), .o_valid(ov), .o_power(op));
	predistortion_gain_loop_control dut (.i_mclk(mclk), .i_rst(rst),
		.i_low_power_threshold(32'h1000_0000), .i_peak_level_threshold(32'h6000_0000),
		.i_low_power_count_limit(llim), .i_peak_count_limit(plim), .i_sample_count(13'h0010),
		.i_capture_start_delay(dly), .i_loopback_path_delay(skip[7:0]),
		.i_immediate_table_swap(imm), .i_table_reset(trst), .i_swap_smoothing_coeff(sc),
		.i_gain_loop_open(lopen), .i_gain_target(target), .i_gain_smoothing_coeff(gc),
		.i_frame_start(fs), .i_frame_end(fe), .i_obs_valid(ov), .i_obs_power(op),
		.i_solution_valid(sv), .i_solution_word(word), .i_solution_last(sl), .o_solution_ready(rdy),
		.i_gain_valid(gv), .i_gain_meas(meas), .i_lut_rd(rd), .i_lut_addr(addr), .o_lut_data(q),
		.o_lut_data_valid(rdv), .o_table_bank(bank), .o_capture_busy(busy), .o_capture_done(done),
		.o_capture_valid(ok), .o_raw_gain_reading(raw), .o_smoothed_gain_reading(smo),
		.o_tx_atten(att), .o_atten_update(upd), .o_predistortion_sample_rate(rate));
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask : tick
	task automatic burst(input logic [12:0] nl, input logic [12:0] np);
		nlow = nl;
		npk = np;
		go = 1'b1;
		tick(1);
		go = 1'b0;
	endtask : burst
	// lows sent inside the delay window must be ignored
	task automatic capture(input logic [15:0] d, input logic [12:0] ll, input logic [12:0] pl,
		input logic [12:0] nl, input logic [12:0] np, input logic exp);
		dly = d;
		llim = ll;
		plim = pl;
		fs = 1'b1;
		if (d != 16'h0000)
			burst(13'h0010, 13'h0000);
		else
			tick(1);
		fs = 1'b0;
		tick(d * 100 + 2);
		burst(nl, np);
		for (int i = 0; i < 400 && done !== 1'b1; i++)
			tick(1);
		chk("capture_done", done, 1'b1);
		chk("capture_valid", ok, exp);
	endtask : capture
	task automatic put(input logic [31:0] w, input logic last);
		word = w;
		sl = last;
		sv = 1'b1;
		for (int i = 0; i < 50 && rdy !== 1'b1; i++)
			tick(1);
		tick(1);
	endtask : put
	task automatic read(input logic [3:0] a, input logic [31:0] exp);
		addr = a;
		rd = 1'b1;
		tick(1);
		chk("lut_data", q, exp);
	endtask : read
	task automatic gain(input logic signed [31:0] m);
		meas = m;
		gv = 1'b1;
		tick(1);
		gv = 1'b0;
	endtask : gain
	initial begin
		tick(5);
		rst = 1'b0;
		chk("solution_ready", rdy, 1'b1);
		chk("tx_atten", att, 10'h000);
		chk("sample_rate", rate, `SAMPLE_RATE_HZ);
		trst = 1'b1;
		tick(3);
		trst = 1'b0;
		read(4'h0, `TABLE_UNITY);
		read(4'h5, `TABLE_ZERO);
		rd = 1'b0;
		$display("test reset and table clear done");
		capture(16'h0000, 13'h0004, 13'h0000, 13'h0005, 13'h0000, 1'b0);
		capture(16'h0000, 13'h0005, 13'h0000, 13'h0005, 13'h0000, 1'b1);
		capture(16'h0000, 13'h1000, 13'h0000, 13'h0010, 13'h0000, 1'b1);
		capture(16'h0000, 13'h1000, 13'h0003, 13'h0000, 13'h0003, 1'b0);
		capture(16'h0000, 13'h1000, 13'h0003, 13'h0004, 13'h0004, 1'b1);
		slow = 1'b1;
		capture(16'h0001, 13'h1000, 13'h0003, 13'h0000, 13'h0004, 1'b1);
		slow = 1'b0;
		$display("test capture qualification done");
		for (int k = 0; k < 16; k++)
			put(32'h0000_1000 + k, k == 15);
		sv = 1'b0;
		tick(4);
		chk("table_bank", bank, 1'b1);
		read(4'h3, 32'h0000_1003);
		rd = 1'b0;
		imm = 1'b0;
		for (int k = 0; k < 18; k++)
			put(32'h0000_2000 + k, k == 15);
		sv = 1'b0;
		tick(3);
		chk("solution_ready", rdy, 1'b0);
		chk("table_bank", bank, 1'b1);
		fe = 1'b1;
		tick(1);
		fe = 1'b0;
		tick(3);
		chk("table_bank", bank, 1'b0);
		chk("solution_ready", rdy, 1'b1);
		read(4'hF, 32'h0000_200F);
		sc = 17'h0_8000;
		read(4'h3, 32'h0000_2009);
		rd = 1'b0;
		$display("test table swap done");
		gain(32'sd123);
		chk("raw_gain", raw, 32'sd123);
		chk("smoothed_gain", smo, 32'sd123);
		gc = `GAIN_COEFF_RESET;
		gain(32'sd523);
		chk("raw_gain", raw, 32'sd523);
		chk("smoothed_gain", smo, 32'sd223);
		chk("tx_atten", att, 10'h000);
		lopen = 1'b0;
		gc = 17'h0_0000;
		target = -32'sd500;
		gain(32'sd600);
		chk("tx_atten", att, 10'h001);
		chk("atten_update", upd, 1'b1);
		chk("raw_gain", raw, 32'sd523);
		gain(32'sd600);
		chk("tx_atten", att, 10'h002);
		target = 32'sd3000;
		gain(32'sd600);
		chk("tx_atten", att, 10'h001);
		target = 32'sd595;
		gain(32'sd600);
		chk("atten_update", upd, 1'b0);
		$display("test gain loop done");
		print_verdict();
	end
endmodule : tb_predistortion_gain_loop_control
bind predistortion_gain_loop_control pdgl_assertions checker_u (.i_mclk, .i_rst, .i_frame_start,
	.i_lut_rd, .i_gain_loop_open, .i_gain_valid, .i_gain_meas, .i_gain_smoothing_coeff,
	.o_lut_data_valid, .o_table_bank, .o_capture_busy, .o_capture_done, .o_capture_valid,
	.o_raw_gain_reading, .o_smoothed_gain_reading, .o_tx_atten, .o_atten_update,
	.o_predistortion_sample_rate);
`default_nettype wire
